// ---- design/qdw_lba_trk.sv ----
`timescale 1ns/10ps
module qdw_lba_trk
	import qdw_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              ce_i,
	// Control from the command engine.
	input  wire logic              load_i,
	input  wire logic [LBA_W-1:0]  lba_i,
	input  wire logic              step_i,
	input  wire logic              capt_i,
	input  wire logic              hob_i,
	// Tracked addresses.
	output logic      [LBA_W-1:0]  cur_lba_o,
	output logic      [HALF_W-1:0] err_half_o
);

	logic [LBA_W-1:0] cur_r;
	logic [LBA_W-1:0] err_r;

	// The failing address is shown low half or high half as the select bit asks.
	assign cur_lba_o  = cur_r;
	assign err_half_o = hob_i ? err_r[LBA_W-1:HALF_W] : err_r[HALF_W-1:0];

	// Current sector address: loaded at start, advanced after each sector is on media.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cur_r <= '0;
		end else if (ce_i) begin
			if (load_i) begin
				cur_r <= lba_i;
			end else if (step_i) begin
				cur_r <= cur_r + {{(LBA_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// The address of the first failing sector is held for software.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			err_r <= '0;
		end else if (ce_i && capt_i) begin
			err_r <= cur_r;
		end
	end

endmodule // qdw_lba_trk

// ---- design/qdw_pkg.sv ----
package qdw_pkg;

	// Register byte addresses on the APB port.
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_CMD      = 8'h04;
	localparam logic [7:0] ADDR_COUNT    = 8'h08;
	localparam logic [7:0] ADDR_LBA_CUR  = 8'h0C;
	localparam logic [7:0] ADDR_LBA_PRV  = 8'h10;
	localparam logic [7:0] ADDR_DEVHEAD  = 8'h14;
	localparam logic [7:0] ADDR_TAG      = 8'h18;
	localparam logic [7:0] ADDR_STATUS   = 8'h1C;
	localparam logic [7:0] ADDR_ERR_LBA  = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;

	// Command code of the queued first-party-DMA write.
	localparam logic [7:0] CMD_WR_FPDMA = 8'h61;

	// Field positions.
	localparam int CTRL_WCE_BIT  = 0;
	localparam int CTRL_HOB_BIT  = 1;
	localparam int FUA_BIT       = 7;
	localparam int TAG_MSB       = 7;
	localparam int TAG_LSB       = 3;
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_CMPL_BIT   = 1;
	localparam int ST_ERR_BIT    = 2;
	localparam int ST_ABT_BIT    = 3;
	localparam int ST_TAG_LSB    = 8;
	localparam int ST_TAG_MSB    = 12;

	// Widths and sizes.
	localparam int LBA_W   = 48;
	localparam int HALF_W  = 24;
	localparam int CNT_W   = 17;
	localparam int TAG_W   = 5;
	localparam int IRQ_W   = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR  = 1;
	localparam int IRQ_ABT  = 2;

	// A zero sector count stands for this many sectors.
	localparam logic [CNT_W-1:0] CNT_ZERO_MEANS = 17'h10000;
	localparam logic [CNT_W-1:0] CNT_ONE        = 17'h00001;

	// Reset values.
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Command engine states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RECV,
		ST_WRITE
	} qdw_state_t;

endpackage

// ---- design/qdw_top.sv ----
//Contract
// - Command code 61h starts the queued DMA write; other codes are aborted. A code written while the engine is busy is ignored.
// - Accept one or more sectors from the host, then commit them to media.
// - Sector count low byte is current count, high byte is previous count.
// - An assembled sector count of zero means 65,536 sectors.
// - On an unrecoverable error stop at the failing sector, write nothing after.
// - Force-unit-access set: report completion only after data is on media.
// - Force-unit-access clear with write cache on: completion may precede media write.
// - With high-order select clear, report failing LBA bits 23:0.
// - With high-order select set, report failing LBA bits 47:24.
`timescale 1ns/10ps
module qdw_top
	import qdw_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              ce_i,
	// APB slave.
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [7:0]        paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Host sector stream.
	input  wire logic              sec_vld_i,
	output logic                   sec_rdy_o,
	// Media write port.
	output logic                   med_req_o,
	output logic      [LBA_W-1:0]  med_lba_o,
	input  wire logic              med_done_i,
	input  wire logic              med_err_i,
	// Interrupt.
	output logic                   irq_o
);

	qdw_state_t        state_r;
	qdw_state_t        state_nxt;
	logic [31:0]       prdata_r;
	logic              pready_r;
	logic              pslverr_r;
	logic              sec_rdy_r;
	logic              med_req_r;
	logic              irq_r;
	logic [1:0]        ctrl_r;
	logic [15:0]       count_r;
	logic [HALF_W-1:0] lba_cur_r;
	logic [HALF_W-1:0] lba_prv_r;
	logic              fua_r;
	logic [TAG_W-1:0]  tag_r;
	logic [TAG_W-1:0]  act_tag_r;
	logic              act_fua_r;
	logic              act_early_r;
	logic [CNT_W-1:0]  rcv_left_r;
	logic [CNT_W-1:0]  wr_left_r;
	logic              cmpl_r;
	logic              err_r;
	logic              abt_r;
	logic [IRQ_W-1:0]  irq_stat_r;
	logic [IRQ_W-1:0]  irq_stat_nxt;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic [IRQ_W-1:0]  irq_ev;
	logic [LBA_W-1:0]  cur_lba;
	logic [HALF_W-1:0] err_half;

	// Bus phase decode: a request is taken at the access edge only.
	wire setup_ph = psel_i && !penable_i;
	wire acc_ph   = psel_i && penable_i && pready_r;
	wire wr_acc   = acc_ph && pwrite_i;
	wire busy     = (state_r != ST_IDLE);

	// Write decode per register.
	wire wr_ctrl  = wr_acc && (paddr_i == ADDR_CTRL);
	wire wr_cmd   = wr_acc && (paddr_i == ADDR_CMD);
	wire wr_count = wr_acc && (paddr_i == ADDR_COUNT) && !busy;
	wire wr_lbac  = wr_acc && (paddr_i == ADDR_LBA_CUR) && !busy;
	wire wr_lbap  = wr_acc && (paddr_i == ADDR_LBA_PRV) && !busy;
	wire wr_dev   = wr_acc && (paddr_i == ADDR_DEVHEAD) && !busy;
	wire wr_tag   = wr_acc && (paddr_i == ADDR_TAG) && !busy;
	wire wr_istat = wr_acc && (paddr_i == ADDR_IRQ_STAT);
	wire wr_imask = wr_acc && (paddr_i == ADDR_IRQ_MASK);

	// Command launch: while idle, the queued write code starts, anything else is aborted.
	wire cmd_ok   = wr_cmd && !busy && (pwdata_i[7:0] == CMD_WR_FPDMA);
	wire cmd_bad  = wr_cmd && !busy && (pwdata_i[7:0] != CMD_WR_FPDMA);

	// A zero count stands for the full 65,536 sectors.
	wire [CNT_W-1:0] count_ext = (count_r == 16'h0000) ? CNT_ZERO_MEANS : {1'b0, count_r};

	// Early completion is allowed when caching is on and force-unit-access is clear.
	wire early_ok = ctrl_r[CTRL_WCE_BIT] && !fua_r;

	// Sector handshakes.
	wire sec_take  = (state_r == ST_RECV) && sec_rdy_r && sec_vld_i;
	wire last_rcv  = sec_take && (rcv_left_r == CNT_ONE);
	wire med_ok    = (state_r == ST_WRITE) && med_req_r && med_done_i && !med_err_i;
	wire med_fail  = (state_r == ST_WRITE) && med_req_r && med_err_i;
	wire last_wr   = med_ok && (wr_left_r == CNT_ONE);
	wire done_ev   = (last_rcv && act_early_r) || (last_wr && !act_early_r);

	// Next state of the command engine.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (cmd_ok) begin
					state_nxt = ST_RECV;
				end
			end
			ST_RECV: begin
				if (last_rcv) begin
					state_nxt = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (med_fail || last_wr) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	// Engine state and handshake outputs follow the next state.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r   <= ST_IDLE;
			sec_rdy_r <= 1'b0;
			med_req_r <= 1'b0;
		end else if (ce_i) begin
			state_r   <= state_nxt;
			sec_rdy_r <= (state_nxt == ST_RECV);
			med_req_r <= (state_nxt == ST_WRITE) && !med_ok;
		end
	end

	// Sector counters for reception and media commit.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rcv_left_r <= '0;
			wr_left_r  <= '0;
		end else if (ce_i) begin
			if (cmd_ok) begin
				rcv_left_r <= count_ext;
				wr_left_r  <= count_ext;
			end else begin
				if (sec_take) begin
					rcv_left_r <= rcv_left_r - CNT_ONE;
				end
				if (med_ok) begin
					wr_left_r <= wr_left_r - CNT_ONE;
				end
			end
		end
	end

	// Per-command copy of tag and completion mode, frozen at launch.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			act_tag_r   <= '0;
			act_fua_r   <= 1'b0;
			act_early_r <= 1'b0;
		end else if (ce_i && cmd_ok) begin
			act_tag_r   <= tag_r;
			act_fua_r   <= fua_r;
			act_early_r <= early_ok;
		end
	end

	// Command status: completion, error and abort are held until the next launch.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cmpl_r <= 1'b0;
			err_r  <= 1'b0;
			abt_r  <= 1'b0;
		end else if (ce_i) begin
			if (cmd_ok) begin
				cmpl_r <= 1'b0;
				err_r  <= 1'b0;
				abt_r  <= 1'b0;
			end else begin
				if (done_ev) begin
					cmpl_r <= 1'b1;
				end
				if (med_fail) begin
					err_r <= 1'b1;
				end
				if (cmd_bad) begin
					abt_r <= 1'b1;
				end
			end
		end
	end

	// Command block registers written by software.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_r    <= '0;
			count_r   <= '0;
			lba_cur_r <= '0;
			lba_prv_r <= '0;
			fua_r     <= 1'b0;
			tag_r     <= '0;
		end else if (ce_i) begin
			if (wr_ctrl) ctrl_r <= pwdata_i[1:0];
			if (wr_count) count_r <= pwdata_i[15:0];
			if (wr_lbac) lba_cur_r <= pwdata_i[HALF_W-1:0];
			if (wr_lbap) lba_prv_r <= pwdata_i[HALF_W-1:0];
			if (wr_dev) fua_r <= pwdata_i[FUA_BIT];
			if (wr_tag) tag_r <= pwdata_i[TAG_MSB:TAG_LSB];
		end
	end

	// Address tracking and failing-address capture.
	qdw_lba_trk u_trk (
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.ce_i       (ce_i),
		.load_i     (cmd_ok),
		.lba_i      ({lba_prv_r, lba_cur_r}),
		.step_i     (med_ok),
		.capt_i     (med_fail),
		.hob_i      (ctrl_r[CTRL_HOB_BIT]),
		.cur_lba_o  (cur_lba),
		.err_half_o (err_half)
	);

	// Interrupt events; a set in the same cycle as a clear wins.
	assign irq_ev = {cmd_bad, med_fail, done_ev};
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
			assign irq_stat_nxt[gi] = irq_ev[gi] || (irq_stat_r[gi] && !(wr_istat && pwdata_i[gi]));
		end
	endgenerate

	// Sticky status, mask and the level interrupt.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq_r      <= 1'b0;
		end else if (ce_i) begin
			irq_stat_r <= irq_stat_nxt;
			if (wr_imask) irq_mask_r <= pwdata_i[IRQ_W-1:0];
			irq_r <= |(irq_stat_nxt & (wr_imask ? pwdata_i[IRQ_W-1:0] : irq_mask_r));
		end
	end

	// Read data selection.
	wire [31:0] st_word = {19'h0, act_tag_r, 4'h0, abt_r, err_r, cmpl_r, busy};
	wire mapped = (paddr_i <= ADDR_IRQ_MASK) && (paddr_i[1:0] == 2'h0);
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = RST_WORD;
		unique case (paddr_i)
			ADDR_CTRL:     rd_mux = {30'h0, ctrl_r};
			ADDR_COUNT:    rd_mux = {16'h0, count_r};
			ADDR_LBA_CUR:  rd_mux = {8'h0, lba_cur_r};
			ADDR_LBA_PRV:  rd_mux = {8'h0, lba_prv_r};
			ADDR_DEVHEAD:  rd_mux = {24'h0, fua_r, 7'h0};
			ADDR_TAG:      rd_mux = {24'h0, tag_r, 3'h0};
			ADDR_STATUS:   rd_mux = st_word;
			ADDR_ERR_LBA:  rd_mux = {8'h0, err_half};
			ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
			ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
			default:       rd_mux = RST_WORD;
		endcase
	end

	// APB answer: ready for exactly the first access cycle, data latched in setup.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= RST_WORD;
		end else if (ce_i) begin
			pready_r  <= setup_ph;
			pslverr_r <= setup_ph && !mapped;
			if (setup_ph) prdata_r <= (mapped && !pwrite_i) ? rd_mux : RST_WORD;
		end
	end

	assign prdata_o  = prdata_r;
	assign pready_o  = pready_r;
	assign pslverr_o = pslverr_r;
	assign sec_rdy_o = sec_rdy_r;
	assign med_req_o = med_req_r;
	assign med_lba_o = cur_lba;
	assign irq_o     = irq_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i || !ce_i);

	sequence s_last_sector;
		(state_r == ST_RECV) && last_rcv;
	endsequence

	sequence s_media_fail;
		(state_r == ST_WRITE) && med_fail;
	endsequence

	// One sector reached the media while the engine is committing.
	sequence s_sector_ok;
		(state_r == ST_WRITE) && med_ok;
	endsequence

	a_start_recv: assert property (cmd_ok |=> (state_r == ST_RECV) && sec_rdy_o)
		else $error("Queued write command did not start reception.");
	a_bad_abort: assert property (cmd_bad |=> abt_r && (state_r == ST_IDLE) && irq_stat_r[IRQ_ABT])
		else $error("Unknown command was not aborted.");
	a_count_asm: assert property (cmd_ok && (count_r != 16'h0000) |=> rcv_left_r == {1'b0, $past(count_r)})
		else $error("Sector count not assembled from both bytes.");
	a_zero_count: assert property (cmd_ok && (count_r == 16'h0000) |=> rcv_left_r == CNT_ZERO_MEANS)
		else $error("Zero sector count did not mean 65536 sectors.");
	a_recv_commit: assert property (s_last_sector |=> (state_r == ST_WRITE) && med_req_o && !sec_rdy_o)
		else $error("Media commit did not follow reception.");
	a_err_stop: assert property (s_media_fail |=> !med_req_o && (state_r == ST_IDLE) ##1 !med_req_o)
		else $error("Writing continued after a failing sector.");
	a_fua_late: assert property ($rose(cmpl_r) && act_fua_r |-> $past(state_r) == ST_WRITE)
		else $error("Completion reported before media write with force-unit-access.");
	a_cache_early: assert property ((s_last_sector and act_early_r) |=> cmpl_r && !err_r)
		else $error("Cached write did not complete after reception.");
	a_fail_lba: assert property (s_media_fail |=> err_half == (ctrl_r[CTRL_HOB_BIT] ?
		$past(med_lba_o[LBA_W-1:HALF_W]) : $past(med_lba_o[HALF_W-1:0])))
		else $error("Failing sector address not reported.");
	a_lba_load: assert property (cmd_ok |=> med_lba_o == {$past(lba_prv_r), $past(lba_cur_r)})
		else $error("Starting address not assembled from both halves.");

	// Late completion must not be reported when the last sector is only received.
	a_fua_wait: assert property ((s_last_sector and !act_early_r) |=> !cmpl_r)
		else $error("Completion reported on reception without early completion allowed.");
	a_sector_step: assert property (s_sector_ok ##0 (wr_left_r != CNT_ONE) |=> !med_req_o ##1
		med_req_o && (med_lba_o == $past(med_lba_o, 2) + 1))
		else $error("Next sector was not requested at the following address.");
	a_unmapped_err: assert property (setup_ph && !mapped |=> pslverr_o && pready_o && (prdata_o == RST_WORD))
		else $error("Unmapped access was not answered with an error.");

endmodule // qdw_top

// ---- tb/qdw_host_mdl.sv ----
`timescale 1ns/10ps
module qdw_host_mdl
	import qdw_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	// Behaviour settings.
	input  wire logic [7:0]       dly_i,
	input  wire logic             slow_i,
	input  wire logic             err_en_i,
	input  wire logic [LBA_W-1:0] err_lba_i,
	// Sector stream.
	input  wire logic             sec_rdy_i,
	output logic                  sec_vld_o,
	// Media port.
	input  wire logic             med_req_i,
	input  wire logic [LBA_W-1:0] med_lba_i,
	output logic                  med_done_o,
	output logic                  med_err_o
);
	logic [7:0] wait_r;
	logic       ans_r;
	logic       hit_r;

	// A slow host holds an offer until taken, then leaves one idle cycle.
	always_ff @(posedge clk_i) begin
		if (srst_i)
			sec_vld_o <= 1'b0;
		else
			sec_vld_o <= slow_i ? (~sec_vld_o | ~sec_rdy_i) : 1'b1;
	end

	// The media answers a standing request after dly_i cycles, failing at err_lba_i.
	always_ff @(posedge clk_i) begin
		if (srst_i || !med_req_i || ans_r) begin
			wait_r <= 8'h00;
			ans_r  <= 1'b0;
		end else if (wait_r == dly_i) begin
			ans_r <= 1'b1;
			hit_r <= err_en_i && (med_lba_i == err_lba_i);
		end else begin
			wait_r <= wait_r + 8'h01;
		end
	end

	// The answer is a one-cycle pulse of either kind.
	assign med_done_o = ans_r & ~hit_r;
	assign med_err_o  = ans_r & hit_r;
endmodule // qdw_host_mdl

// ---- tb/queued_dma_write_command_tb.sv ----
`timescale 1ns/10ps
module queued_dma_write_command_tb
	import qdw_pkg::*;
;
	logic             clk_i   = 1'b0;
	logic             srst_i  = 1'b1;
	logic             psel    = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite  = 1'b0;
	logic [7:0]       paddr   = 8'h00;
	logic [31:0]      pwdata  = 32'h0;
	logic [7:0]       dly     = 8'h00;
	logic             slow    = 1'b0;
	logic             err_en  = 1'b0;
	logic [LBA_W-1:0] err_lba = 48'h0;
	logic [31:0]      prdata, q;
	logic             pready, pslverr, q_err, err_seen;
	logic             sec_vld, sec_rdy, med_req, med_done, med_err, irq;
	logic [LBA_W-1:0] med_lba, first_lba, last_lba;
	int               error_cnt, checks_done, rx_cnt, wr_cnt, late;

	// The clock toggles every half period of 25 ns.
	always #25 clk_i = ~clk_i;

	qdw_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .sec_vld_i(sec_vld), .sec_rdy_o(sec_rdy), .med_req_o(med_req),
		.med_lba_o(med_lba), .med_done_i(med_done), .med_err_i(med_err), .irq_o(irq));

	qdw_host_mdl i_host (.clk_i(clk_i), .srst_i(srst_i), .dly_i(dly), .slow_i(slow), .err_en_i(err_en),
		.err_lba_i(err_lba), .sec_rdy_i(sec_rdy), .sec_vld_o(sec_vld), .med_req_i(med_req),
		.med_lba_i(med_lba), .med_done_o(med_done), .med_err_o(med_err));

	// Sectors received and written are counted at the handshakes.
	always @(posedge clk_i) begin
		if (sec_vld && sec_rdy)
			rx_cnt++;
		if (med_req && med_err)
			err_seen = 1'b1;
		if (med_req && med_done) begin
			if (wr_cnt == 0)
				first_lba = med_lba;
			last_lba = med_lba;
			wr_cnt++;
		end
	end

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; read data is taken at the edge that sees pready.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do
			@(posedge clk_i);
		while (pready !== 1'b1);
		q = prdata;
		q_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic issue(input logic [7:0] code, input logic [15:0] cnt, input logic [47:0] lba,
		input logic [1:0] ctrl, input logic fua, input logic [4:0] tag);
		rx_cnt = 0;
		wr_cnt = 0;
		err_seen = 1'b0;
		apb(1'b1, ADDR_CTRL, {30'h0, ctrl});
		apb(1'b1, ADDR_COUNT, {16'h0, cnt});
		apb(1'b1, ADDR_LBA_CUR, {8'h0, lba[23:0]});
		apb(1'b1, ADDR_LBA_PRV, {8'h0, lba[47:24]});
		apb(1'b1, ADDR_DEVHEAD, {24'h0, fua, 7'h00});
		apb(1'b1, ADDR_TAG, {24'h0, tag, 3'h0});
		apb(1'b1, ADDR_CMD, {24'h0, code});
	endtask

	task automatic wait_wr(input int n);
		for (int i = 0; i < 5000 && wr_cnt < n; i++)
			@(posedge clk_i);
		repeat (4) @(posedge clk_i);
	endtask

	task automatic summarize;
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence: reset, abort, uncached, cached, forced and failing writes.
	initial begin
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q, 48'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({q_err, q}, 48'h1_0000_0000);
		issue(8'h35, 16'h0001, 48'h0, 2'b00, 1'b0, 5'd0);
		repeat (2) @(posedge clk_i);
		chk(sec_rdy, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[3:0], 4'h8);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk({irq, q[2:0]}, 4'h4);
		apb(1'b1, ADDR_IRQ_MASK, 32'h4);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h4);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk({irq, q[2:0]}, 4'h0);
		dly  <= 8'h03;
		slow <= 1'b1;
		issue(CMD_WR_FPDMA, 16'h0102, 48'hA1B2C3_D4E5F6, 2'b00, 1'b0, 5'd1);
		wait_wr(258);
		chk(rx_cnt, 258);
		chk(wr_cnt, 258);
		chk(first_lba, 48'hA1B2C3_D4E5F6);
		chk(last_lba, 48'hA1B2C3_D4E6F7);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[3:0], 4'h2);
		apb(1'b1, ADDR_IRQ_STAT, 32'h7);
		dly  <= 8'd40;
		slow <= 1'b0;
		issue(CMD_WR_FPDMA, 16'h0002, 48'h10, 2'b01, 1'b0, 5'd2);
		repeat (8) @(posedge clk_i);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({wr_cnt[0], q[1]}, 2'b01);
		wait_wr(2);
		issue(CMD_WR_FPDMA, 16'h0002, 48'h20, 2'b01, 1'b1, 5'd3);
		repeat (8) @(posedge clk_i);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({rx_cnt[1:0], q[1]}, 3'b100);
		wait_wr(2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[1:0], 2'b10);
		dly     <= 8'h01;
		err_en  <= 1'b1;
		err_lba <= 48'h123457_000001;
		issue(CMD_WR_FPDMA, 16'h0000, 48'h123456_FFFFFE, 2'b00, 1'b0, 5'd4);
		for (int i = 0; i < 70000 && !err_seen; i++)
			@(posedge clk_i);
		late = 0;
		repeat (20) begin
			@(posedge clk_i);
			if (med_req !== 1'b0)
				late++;
		end
		chk(rx_cnt, 65536);
		chk({wr_cnt[15:0], late[15:0]}, {16'd3, 16'd0});
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[2:1], 2'b10);
		apb(1'b0, ADDR_ERR_LBA, 32'h0);
		chk(q[23:0], 24'h000001);
		apb(1'b1, ADDR_CTRL, 32'h2);
		apb(1'b0, ADDR_ERR_LBA, 32'h0);
		chk(q[23:0], 24'h123457);
		summarize;
	end

	// A hang is cut short well after the expected run length.
	initial begin
		repeat (90000) @(posedge clk_i);
		error_cnt++;
		summarize;
	end
endmodule // queued_dma_write_command_tb
